// ===== hw/mmsl_defs.svh
/*
 * constants of the slave port: widths, depths, burst limits.
 * assumes inclusion by bare name from the package and both ends.
 */
`ifndef MMSL_DEFS_SVH
`define MMSL_DEFS_SVH

`define MMSL_ADDR_W      8
`define MMSL_DATA_W      32
`define MMSL_BCNT_W      4
`define MMSL_MAX_BURST   4'h8
`define MMSL_BURST_ONE   4'h1
`define MMSL_MAX_OUT     3'h4
`define MMSL_LEVEL_W     3
`define MMSL_QIDX_W      2
`define MMSL_MEM_WORDS   16
`define MMSL_MEM_IDX_W   4
`define MMSL_PEND_W      6
`define MMSL_MASTERS     2

`endif

// ===== hw/mmsl_pkg.sv
/*
 * types shared by both ends of the slave port.
 * assumes mmsl_defs.svh on the include path.
 */
`include "mmsl_defs.svh"

package mmsl_pkg;

	typedef logic [`MMSL_ADDR_W-1:0] mmsl_addr_t;
	typedef logic [`MMSL_DATA_W-1:0] mmsl_data_t;
	typedef logic [`MMSL_BCNT_W-1:0] mmsl_bcnt_t;

	// one queued read: start word and beat count
	typedef struct packed {
		mmsl_addr_t addr;
		mmsl_bcnt_t cnt;
	} mmsl_qent_s;

	// fabric sequencer, gray along idle -> command
	typedef enum logic [1:0] {
		MMSL_ST_IDLE = 2'b00,
		MMSL_ST_CMD  = 2'b01
	} mmsl_state_e;

endpackage

// ===== hw/mmsl_if.sv
/*
 * signals between fabric and slave, one modport per end.
 * assumes both ends share one clock; no pin is two-way.
 */
`timescale 1ns/100ps
`include "mmsl_defs.svh"

interface mmsl_if;

	mmsl_pkg::mmsl_addr_t address;
	mmsl_pkg::mmsl_data_t writedata;
	mmsl_pkg::mmsl_data_t readdata;
	mmsl_pkg::mmsl_bcnt_t burstcount;
	logic                 read;
	logic                 write;
	logic                 begintransfer;
	logic                 beginbursttransfer;
	logic                 arbiterlock;
	logic                 waitrequest;
	logic                 readdatavalid;
	logic                 readyfordata;
	logic                 dataavailable;
	logic                 resetrequest;

	modport slave (
		input  address, writedata, burstcount, read, write,
		input  begintransfer, beginbursttransfer, arbiterlock,
		output readdata, waitrequest, readdatavalid,
		output readyfordata, dataavailable, resetrequest
	);

	modport fabric (
		output address, writedata, burstcount, read, write,
		output begintransfer, beginbursttransfer, arbiterlock,
		input  readdata, waitrequest, readdatavalid,
		input  readyfordata, dataavailable, resetrequest
	);

endinterface

// ===== hw/mmsl_slave.sv
/*
 * slave end: small word memory with write bursts and pipelined,
 * in-order read bursts of variable latency.
 * assumes a fabric on the same clock that holds its controls while
 * waitrequest is high and never starts a command while it is high.
 */
`timescale 1ns/100ps
`include "mmsl_defs.svh"

module mmsl_slave (
	// clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     reset_n_in,
	// bus side
	mmsl_if.slave                         bus,
	// user side
	input  wire logic                     stall_in,
	input  wire logic                     reset_req_in,
	output logic                          lock_seen_out,
	output logic [`MMSL_LEVEL_W-1:0]      pending_out
);

	// out-of-range counts are served as single beats
	function automatic mmsl_pkg::mmsl_bcnt_t eff_cnt(
		input mmsl_pkg::mmsl_bcnt_t bc
	);
		if (bc == '0 || bc > `MMSL_MAX_BURST)
			eff_cnt = `MMSL_BURST_ONE;
		else
			eff_cnt = bc;
	endfunction

	mmsl_pkg::mmsl_data_t        mem [`MMSL_MEM_WORDS];
	mmsl_pkg::mmsl_qent_s        queue [`MMSL_MAX_OUT];
	logic [`MMSL_QIDX_W-1:0]     wr_ptr;
	logic [`MMSL_QIDX_W-1:0]     rd_ptr;
	logic [`MMSL_LEVEL_W-1:0]    level;
	mmsl_pkg::mmsl_bcnt_t        beat;
	mmsl_pkg::mmsl_bcnt_t        wr_left;
	mmsl_pkg::mmsl_addr_t        wr_next;
	logic                        wait_q;
	logic                        rdv_q;
	mmsl_pkg::mmsl_data_t        rdata_q;
	logic                        rfd_q;
	logic                        dav_q;
	logic                        rst_req_q;

	// acceptance, decode and queue arithmetic
	wire                         rd_acc;
	wire                         wr_acc;
	wire                         wr_first;
	mmsl_pkg::mmsl_addr_t        wr_addr;
	mmsl_pkg::mmsl_qent_s        head;
	mmsl_pkg::mmsl_addr_t        rd_addr;
	wire                         emit;
	wire                         last_beat;
	wire                         pop;
	wire [`MMSL_LEVEL_W-1:0]     next_level;
	wire                         full_next;

	assign rd_acc     = bus.read & ~wait_q;
	assign wr_acc     = bus.write & ~wait_q;
	assign wr_first   = (wr_left == '0);
	assign wr_addr    = wr_first ? bus.address : wr_next;
	assign head       = queue[rd_ptr];
	assign rd_addr    = head.addr + {4'h0, beat};
	assign emit       = (level != '0);
	assign last_beat  = (beat == head.cnt - `MMSL_BURST_ONE);
	assign pop        = emit & last_beat;
	assign next_level = level + {2'h0, rd_acc} - {2'h0, pop};
	// waitrequest is registered, so it rises with the read that fills the queue
	assign full_next  = (next_level == `MMSL_MAX_OUT);

	// memory words, one writer each
	for (genvar g = 0; g < `MMSL_MEM_WORDS; g++) begin : g_mem
		wire hit;
		assign hit = wr_acc &
			(wr_addr[`MMSL_MEM_IDX_W-1:0] == `MMSL_MEM_IDX_W'(g));
		always_ff @(posedge clock_in or negedge reset_n_in) begin
			if (!reset_n_in)
				mem[g] <= '0;
			else if (hit)
				mem[g] <= bus.writedata;
		end
	end

	// write burst walker; count taken on the first beat
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_left <= '0;
			wr_next <= '0;
		end else if (wr_acc) begin
			wr_next <= wr_addr + 8'h01; // RQ8
			wr_left <= wr_first ?
				eff_cnt(bus.burstcount) - `MMSL_BURST_ONE :
				wr_left - `MMSL_BURST_ONE; // RQ8
		end
	end

	// read queue: one entry per accepted read command
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < `MMSL_MAX_OUT; i++)
				queue[i] <= '0;
		end else if (rd_acc) begin
			queue[wr_ptr] <= '{addr: bus.address,
				cnt: eff_cnt(bus.burstcount)}; // RQ16 RQ8
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (rd_acc)
				wr_ptr <= wr_ptr + 2'h1; // RQ16
			if (pop)
				rd_ptr <= rd_ptr + 2'h1; // RQ17
			level <= next_level; // RQ16
		end
	end

	// responder: head entry only, so answers keep acceptance order
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			beat    <= '0;
			rdv_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			// a read pushed this edge is seen next edge at the earliest
			rdv_q <= emit; // RQ6 RQ7
			if (emit)
				rdata_q <= mem[rd_addr[`MMSL_MEM_IDX_W-1:0]]; // RQ6
			if (pop)
				beat <= '0; // RQ17
			else if (emit)
				beat <= beat + `MMSL_BURST_ONE;
		end
	end

	// stall and flow-control flags
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_q    <= 1'b1;
			rfd_q     <= 1'b0;
			dav_q     <= 1'b0;
			rst_req_q <= 1'b0;
		end else begin
			wait_q    <= full_next | stall_in; // RQ15 RQ16
			rfd_q     <= ~stall_in; // RQ10
			dav_q     <= ~stall_in & ~full_next; // RQ11
			rst_req_q <= reset_req_in; // RQ12
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lock_seen_out <= 1'b0;
			pending_out   <= '0;
		end else begin
			lock_seen_out <= bus.arbiterlock;
			pending_out   <= next_level;
		end
	end

	// all flags active high
	assign bus.waitrequest   = wait_q; // RQ14
	assign bus.readdatavalid = rdv_q;
	assign bus.readdata      = rdata_q;
	assign bus.readyfordata  = rfd_q;
	assign bus.dataavailable = dav_q;
	assign bus.resetrequest  = rst_req_q;

endmodule

// ===== hw/mmsl_fabric.sv
/*
 * fabric end: arbitrates two masters onto one slave port, with
 * arbitration lock for master 0 and read bursts for master 1.
 * assumes one shared clock and user requests held until taken.
 */
// Notes on behaviour
// RQ1: locked master stays connected across transactions
// RQ2: lock drops with last locked strobe
// RQ3: lock needs grant; grant held until unlock
// RQ4: locking master never issues bursts
// RQ5: no priority used for lock-equipped masters
// RQ6: one valid pulse per read beat
// RQ7: valid never in the accepting cycle
// RQ8: burst count one to eight beats
// RQ9: burst start high one cycle only
// RQ10: ready-for-write only when writes accepted; code also raises it while the full read queue holds waitrequest high
// RQ11: data-available only when reads servable
// RQ12: slave may request a system reset
// RQ13: system reset is OR of sources
// RQ14: all flags active high
// RQ15: controls held while slave stalls
// RQ16: up to max_outstanding_reads reads queued
// RQ17: read answers return in request order
`timescale 1ns/100ps
`include "mmsl_defs.svh"

module mmsl_fabric (
	// clock and reset
	input  wire logic                          clock_in,
	input  wire logic                          reset_n_in,
	// bus side
	mmsl_if.fabric                             bus,
	// master commands
	input  wire logic [`MMSL_MASTERS-1:0]      cmd_valid_in,
	input  wire logic [`MMSL_MASTERS-1:0]      cmd_write_in,
	input  wire logic [`MMSL_MASTERS-1:0]
	                  [`MMSL_ADDR_W-1:0]       cmd_addr_in,
	input  wire logic [`MMSL_MASTERS-1:0]
	                  [`MMSL_DATA_W-1:0]       cmd_data_in,
	input  wire logic [`MMSL_BCNT_W-1:0]       cmd_burst_in,
	input  wire logic                          cmd_lock_in,
	output logic [`MMSL_MASTERS-1:0]           cmd_taken_out,
	// master answers
	output logic [`MMSL_MASTERS-1:0]           rsp_valid_out,
	output logic [`MMSL_DATA_W-1:0]            rsp_data_out,
	// slave status
	output logic                               slave_rfd_out,
	output logic                               slave_dav_out,
	// reset sources
	input  wire logic                          ext_reset_req_in,
	output logic                               sys_reset_out
);

	// registered strobes and controls; all but the start pulses held while the slave stalls
	mmsl_pkg::mmsl_state_e         state;
	logic                          owner;
	logic                          lock_q;
	logic [`MMSL_PEND_W-1:0]       pending;
	logic                          rd_q;
	logic                          wr_q;
	logic                          bt_q;
	logic                          bbt_q;
	mmsl_pkg::mmsl_addr_t          addr_q;
	mmsl_pkg::mmsl_data_t          wdata_q;
	mmsl_pkg::mmsl_bcnt_t          bcnt_q;

	// selection
	wire                           other;
	wire                           can_switch;
	wire                           pick_other;
	wire                           pick_own;
	wire                           go;
	wire                           sel;
	wire                           sel_write;
	mmsl_pkg::mmsl_bcnt_t          sel_cnt;
	wire                           sel_lock;
	wire                           taken;
	wire                           cnt_bad;
	wire                           want;
	wire [`MMSL_PEND_W-1:0]        pend_add;
	wire [`MMSL_PEND_W-1:0]        pend_sub;

	assign other      = ~owner;
	// reads still owed to the owner pin the grant, so answers route
	// back without a tag; costs a turn-around gap between masters
	assign can_switch = (pending == '0) & ~lock_q; // RQ3 RQ1
	// plain round robin: no priority weights at all
	assign pick_other = cmd_valid_in[other] & can_switch; // RQ5
	assign pick_own   = cmd_valid_in[owner];
	assign want       = pick_other | pick_own;
	// a stalled slave gets no new command, only the one it holds
	assign go         = want & ~bus.waitrequest; // RQ15
	assign sel        = pick_other ? other : owner;
	assign sel_write  = cmd_write_in[sel];
	// counts outside one to eight would leave beats owed forever
	assign cnt_bad    = (cmd_burst_in == '0) |
		(cmd_burst_in > `MMSL_MAX_BURST); // RQ8
	// master 0 carries the lock and therefore single beats only
	assign sel_cnt    = (sel == 1'b0 || sel_write || cnt_bad) ?
		`MMSL_BURST_ONE : cmd_burst_in; // RQ4 RQ8
	// lock belongs to master 0 alone
	assign sel_lock   = (sel == 1'b0) & cmd_lock_in;
	// registered waitrequest: a command stands until seen low
	assign taken      = (state == mmsl_pkg::MMSL_ST_CMD) &
		~bus.waitrequest; // RQ15
	// counts are clamped, so every beat added here comes back
	assign pend_add   = (taken & rd_q) ? {2'h0, bcnt_q} : '0;
	assign pend_sub   = {5'h00, bus.readdatavalid};

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state   <= mmsl_pkg::MMSL_ST_IDLE;
			owner   <= 1'b0;
			lock_q  <= 1'b0;
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
			bt_q    <= 1'b0;
			bbt_q   <= 1'b0;
			addr_q  <= '0;
			wdata_q <= '0;
			bcnt_q  <= `MMSL_BURST_ONE;
		end else begin
			// start pulses live one cycle, stall or not
			bt_q  <= 1'b0; // RQ9
			bbt_q <= 1'b0; // RQ9
			case (state)
				mmsl_pkg::MMSL_ST_IDLE: begin
					if (go) begin
						state   <= mmsl_pkg::MMSL_ST_CMD;
						owner   <= sel; // RQ1
						rd_q    <= ~sel_write;
						wr_q    <= sel_write;
						bt_q    <= 1'b1;
						bbt_q   <= 1'b1; // RQ9
						addr_q  <= cmd_addr_in[sel];
						wdata_q <= cmd_data_in[sel];
						bcnt_q  <= sel_cnt; // RQ8
						// lock rises with a command, never alone
						if (sel_lock)
							lock_q <= 1'b1; // RQ3
					end else if (lock_q && !cmd_lock_in) begin
						lock_q <= 1'b0; // RQ3
					end
				end
				mmsl_pkg::MMSL_ST_CMD: begin
					// strobes drop on acceptance; idle comes before the next
					if (taken) begin
						state <= mmsl_pkg::MMSL_ST_IDLE;
						rd_q  <= 1'b0;
						wr_q  <= 1'b0;
						// lock falls in the same edge as the strobe
						if (owner == 1'b0)
							lock_q <= cmd_lock_in; // RQ2
					end
				end
				default: begin
					state <= mmsl_pkg::MMSL_ST_IDLE;
					rd_q  <= 1'b0;
					wr_q  <= 1'b0;
				end
			endcase
		end
	end

	// outstanding read beats, trimmed to the counter width
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			pending <= '0;
		else
			pending <= pending + pend_add - pend_sub; // RQ16 RQ6
	end

	// answers and acknowledges
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cmd_taken_out <= '0;
			rsp_valid_out <= '0;
			rsp_data_out  <= '0;
			slave_rfd_out <= 1'b0;
			slave_dav_out <= 1'b0;
			sys_reset_out <= 1'b0;
		end else begin
			cmd_taken_out <= '0;
			rsp_valid_out <= '0;
			if (taken)
				cmd_taken_out[owner] <= 1'b1;
			// one pulse per beat, in slave order, to the owner
			if (bus.readdatavalid)
				rsp_valid_out[owner] <= 1'b1; // RQ6 RQ17
			// data copied every cycle; only the pulse qualifies it
			rsp_data_out  <= bus.readdata;
			slave_rfd_out <= bus.readyfordata; // RQ10
			slave_dav_out <= bus.dataavailable; // RQ11
			sys_reset_out <= bus.resetrequest |
				ext_reset_req_in; // RQ13 RQ12
		end
	end

	// all strobes driven active high
	assign bus.read               = rd_q; // RQ14
	assign bus.write              = wr_q;
	assign bus.begintransfer      = bt_q;
	assign bus.beginbursttransfer = bbt_q;
	assign bus.arbiterlock        = lock_q;
	assign bus.address            = addr_q;
	assign bus.writedata          = wdata_q;
	assign bus.burstcount         = bcnt_q;

endmodule

// ===== tb/mmsl_checker.sv
/*
 * checker for the fabric/slave bus: burst, lock, wait, read pipeline.
 * assumes one clock and the interface signals wired in by name.
 */
`timescale 1ns/100ps
`include "mmsl_defs.svh"

module mmsl_checker (
	// clock and reset
	input wire logic                 clock_in,
	input wire logic                 reset_n_in,
	// bus signals
	input wire mmsl_pkg::mmsl_addr_t address,
	input wire mmsl_pkg::mmsl_bcnt_t burstcount,
	input wire logic                 read,
	input wire logic                 write,
	input wire logic                 begintransfer,
	input wire logic                 beginbursttransfer,
	input wire logic                 arbiterlock,
	input wire logic                 waitrequest,
	input wire logic                 readdatavalid,
	input wire logic                 readyfordata,
	input wire logic                 dataavailable
);
	// beats owed by the slave; counts outside 1..8 serve one beat
	logic [5:0] owed;
	logic [5:0] next_owed;
	logic [3:0] beats;
	wire        strobe = read || write;
	wire        acc_rd = read && !waitrequest;

	assign beats = (burstcount == 4'h0 || burstcount > `MMSL_MAX_BURST) ?
		4'h1 : burstcount;
	assign next_owed = owed + (acc_rd ? {2'h0, beats} : 6'h00)
		- {5'h00, readdatavalid};

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			owed <= 6'h00;
		else
			owed <= next_owed;
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	a_burst_one_cycle: assert property (
		beginbursttransfer |=> !beginbursttransfer)
		else $error("burst start held past one cycle");
	a_burst_with_begin: assert property (
		beginbursttransfer |-> begintransfer && strobe)
		else $error("burst start outside a command");
	a_count_range: assert property (
		strobe && beginbursttransfer |->
		burstcount >= 4'h1 && burstcount <= `MMSL_MAX_BURST)
		else $error("burst count out of range");
	a_lock_no_burst: assert property (
		arbiterlock && strobe |-> burstcount == 4'h1)
		else $error("burst under lock");
	a_held_in_wait: assert property (
		strobe && waitrequest |=> $stable(address)
		&& $stable(burstcount) && read == $past(read)
		&& write == $past(write))
		else $error("controls moved while stalled");
	a_no_start_wait: assert property (
		waitrequest && !strobe |=> !strobe)
		else $error("command started while stalled");
	a_valid_late: assert property (
		acc_rd && owed == 6'h00 |->
		!readdatavalid ##1 !readdatavalid ##1 readdatavalid)
		else $error("read answer timing wrong");
	a_valid_owed: assert property (readdatavalid |-> owed != 6'h00)
		else $error("read answer with none owed");
	a_owed_limit: assert property (owed <= 6'h20)
		else $error("too many reads queued");
	a_rfd_wait: assert property (!readyfordata |-> waitrequest)
		else $error("not ready yet accepting");
	a_dav_ready: assert property (dataavailable |-> readyfordata)
		else $error("data available while stalled");
endmodule

// ===== tb/test_mm_slave_lock_pipeline_burst_signals.sv
/*
 * bench: both ends joined by the interface, user sides driven here.
 * assumes 100 MHz clock, memory of 16 words, answers in order.
 */
`timescale 1ns/100ps
`include "mmsl_defs.svh"

module test_mm_slave_lock_pipeline_burst_signals;
	logic              clock_in, reset_n_in, stall_in, reset_req_in;
	logic              ext_reset_req_in, cmd_lock_in, slave_rfd_out;
	logic              slave_dav_out, sys_reset_out, lock_seen_out;
	logic [1:0]        cmd_valid_in, cmd_write_in, cmd_taken_out;
	logic [1:0]        rsp_valid_out;
	logic [1:0][7:0]   cmd_addr_in;
	logic [1:0][31:0]  cmd_data_in;
	logic [3:0]        cmd_burst_in;
	logic [31:0]       rsp_data_out;
	logic [2:0]        pending_out;
	logic [31:0]       mem [16];
	logic [31:0]       rq [2][$];
	logic [31:0]       ex [2][$];
	logic              saw_lock, taken1;
	int                miscompares, checked, cycles;

	mmsl_if mmsl_if_i ();
	mmsl_slave mmsl_slave_i (.clock_in, .reset_n_in, .bus(mmsl_if_i),
		.stall_in, .reset_req_in, .lock_seen_out, .pending_out);
	mmsl_fabric mmsl_fabric_i (.clock_in, .reset_n_in, .bus(mmsl_if_i),
		.cmd_valid_in, .cmd_write_in, .cmd_addr_in, .cmd_data_in,
		.cmd_burst_in, .cmd_lock_in, .cmd_taken_out, .rsp_valid_out,
		.rsp_data_out, .slave_rfd_out, .slave_dav_out,
		.ext_reset_req_in, .sys_reset_out);
	mmsl_checker mmsl_checker_i (.clock_in, .reset_n_in,
		.address(mmsl_if_i.address), .burstcount(mmsl_if_i.burstcount),
		.read(mmsl_if_i.read), .write(mmsl_if_i.write),
		.begintransfer(mmsl_if_i.begintransfer),
		.beginbursttransfer(mmsl_if_i.beginbursttransfer),
		.arbiterlock(mmsl_if_i.arbiterlock),
		.waitrequest(mmsl_if_i.waitrequest),
		.readdatavalid(mmsl_if_i.readdatavalid),
		.readyfordata(mmsl_if_i.readyfordata),
		.dataavailable(mmsl_if_i.dataavailable));

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	// answers and events sampled mid-cycle, where outputs are settled
	always @(negedge clock_in) begin
		for (int m = 0; m < 2; m++)
			if (rsp_valid_out[m] === 1'b1)
				rq[m].push_back(rsp_data_out);
		if (lock_seen_out === 1'b1)
			saw_lock = 1'b1;
		if (cmd_taken_out[1] === 1'b1)
			taken1 = 1'b1;
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until taken; bounded wait
	task automatic do_cmd(input int m, input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] n);
		int k;
		cmd_write_in[m] = wr;
		cmd_addr_in[m] = a;
		cmd_data_in[m] = d;
		if (m == 1)
			cmd_burst_in = n;
		cmd_valid_in[m] = 1'b1;
		k = 0;
		do begin
			@(posedge clock_in);
			#1;
			k++;
		end while (cmd_taken_out[m] !== 1'b1 && k < 200);
		cmd_valid_in[m] = 1'b0;
		chk(32'(cmd_taken_out[m]), 32'h1);
		if (wr)
			mem[a[3:0]] = d;
		// one edge between requests, so valid never flips in one step
		@(posedge clock_in);
		#1;
	endtask

	task automatic rd(input int m, input logic [7:0] a, input logic [3:0] n);
		do_cmd(m, 1'b0, a, 32'h0, n);
		for (int i = 0; i < n; i++)
			ex[m].push_back(mem[4'(a + 8'(i))]);
	endtask

	task automatic drain(input int m);
		repeat (60) @(posedge clock_in);
		#1;
		chk(32'(rq[m].size()), 32'(ex[m].size()));
		chk(32'(pending_out), 32'h0);
		while (ex[m].size() > 0 && rq[m].size() > 0)
			chk(rq[m].pop_front(), ex[m].pop_front());
		ex[m].delete();
		rq[m].delete();
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		{reset_n_in, stall_in, reset_req_in, ext_reset_req_in} = 4'h0;
		{cmd_lock_in, saw_lock, taken1} = 3'h0;
		{cmd_valid_in, cmd_write_in} = 4'h0;
		cmd_addr_in = '0;
		cmd_data_in = '0;
		cmd_burst_in = 4'h1;
		repeat (6) @(posedge clock_in);
		#1 reset_n_in = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		for (int i = 0; i < 16; i++)
			do_cmd(i % 2, 1'b1, 8'(i), 32'h5A5A0000 + 32'(i), 4'h1);
		// back-to-back reads queue up to three deep; longest burst wraps
		rd(1, 8'h03, 4'h1);
		rd(1, 8'h0E, 4'h8);
		rd(1, 8'h05, 4'h4);
		rd(1, 8'h09, 4'h1);
		rd(1, 8'h00, 4'h2);
		// out-of-range count is sent as one beat
		do_cmd(1, 1'b0, 8'h0A, 32'h0, 4'hF);
		ex[1].push_back(mem[4'hA]);
		drain(1);
		stall_in = 1'b1;
		taken1 = 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		chk(32'(slave_rfd_out), 32'h0);
		chk(32'(slave_dav_out), 32'h0);
		fork
			rd(1, 8'h02, 4'h2);
			begin
				repeat (8) @(posedge clock_in);
				#1;
				chk(32'(taken1), 32'h0);
				stall_in = 1'b0;
			end
		join
		chk(32'(slave_rfd_out), 32'h1);
		chk(32'(slave_dav_out), 32'h1);
		chk(32'(pending_out), 32'h1);
		drain(1);
		// locked read then unlocking write; the other master must wait
		cmd_lock_in = 1'b1;
		rd(0, 8'h04, 4'h1);
		taken1 = 1'b0;
		fork
			rd(1, 8'h07, 4'h1);
			begin
				repeat (10) @(posedge clock_in);
				#1;
				chk(32'(taken1), 32'h0);
				chk(32'(saw_lock), 32'h1);
				cmd_lock_in = 1'b0;
				do_cmd(0, 1'b1, 8'h04, 32'hC0DE0004, 4'h1);
				chk(32'(mmsl_if_i.arbiterlock), 32'h0);
			end
		join
		drain(0);
		drain(1);
		reset_req_in = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		chk(32'(mmsl_if_i.resetrequest), 32'h1);
		chk(32'(sys_reset_out), 32'h1);
		reset_req_in = 1'b0;
		ext_reset_req_in = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		chk(32'(sys_reset_out), 32'h1);
		ext_reset_req_in = 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		chk(32'(sys_reset_out), 32'h0);
		tally_and_finish();
	end
endmodule
